/* File: src/wdt_top.v */
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_top (
  input  wire                   clock_i,
  input  wire                   resetn_i,
  input  wire                   ce_i,
  input  wire [`WDT_ADDR_W-1:0] addr_i,
  input  wire [31:0]            wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [31:0]            rdata_o,
  output wire                   irq_o,
  output wire                   sys_reset_o
);
  reg [31:0] load_ff;
  reg [31:0] count_ff;
  reg        run_ff;
  reg        resen_ff;
  reg        ris_ff;
  reg        rst_ff;
  reg [31:0] nxt_rdata;
  wire       locked;
  wire       wr_load;
  wire       wr_ctrl;
  wire       wr_iclr;
  wire       zero_hit;

  wdt_lock u_lock (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .wr_i     (wr_i && (addr_i == `WDT_OFS_LOCK)),
    .wdata_i  (wdata_i),
    .locked_o (locked)
  );

  assign wr_load  = wr_i && (addr_i == `WDT_OFS_LOAD) && !locked;
  assign wr_ctrl  = wr_i && (addr_i == `WDT_OFS_CTRL) && !locked;
  // interrupt clear stays open under lock so the handler can still service it
  assign wr_iclr  = wr_i && (addr_i == `WDT_OFS_ICLR);
  assign zero_hit = run_ff && (count_ff == 32'h00000000);

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_ff  <= `WDT_LOAD_RST;
      count_ff <= `WDT_LOAD_RST;
      run_ff   <= 1'b0;
      resen_ff <= 1'b0;
      ris_ff   <= 1'b0;
      rst_ff   <= 1'b0;
    end else if (ce_i) begin
      if (wr_load) begin
        load_ff <= wdata_i;
      end
      // enable starts counter and interrupt; cleared only by reset
      if (wr_ctrl && wdata_i[`WDT_CTRL_INTEN]) begin
        run_ff <= 1'b1;
      end
      if (wr_ctrl) begin
        resen_ff <= wdata_i[`WDT_CTRL_RESEN];
      end
      // new load value taken at once
      if (wr_load) begin
        count_ff <= wdata_i;
      end else if (zero_hit) begin
        count_ff <= load_ff;
      end else if (wr_iclr && ris_ff) begin
        count_ff <= load_ff;
      end else if (run_ff) begin
        count_ff <= count_ff - 32'h00000001;
      end
      // zero load raises interrupt at once; set wins over clear
      if ((wr_load && (wdata_i == 32'h00000000)) || zero_hit) begin
        ris_ff <= 1'b1;
      end else if (wr_iclr) begin
        ris_ff <= 1'b0;
      end
      // second timeout with flag still set
      if (zero_hit && ris_ff && resen_ff) begin
        rst_ff <= 1'b1;
      end
    end
  end

  // interrupt gated by the running enable
  assign irq_o       = ris_ff && run_ff;
  assign sys_reset_o = rst_ff;

  always @* begin
    nxt_rdata = 32'h00000000;
    if (addr_i == `WDT_OFS_LOAD) begin
      nxt_rdata = load_ff;
    // live count, read has no side effect
    end else if (addr_i == `WDT_OFS_VALUE) begin
      nxt_rdata = count_ff;
    end else if (addr_i == `WDT_OFS_CTRL) begin
      nxt_rdata = {30'h00000000, resen_ff, run_ff};
    end else if (addr_i == `WDT_OFS_RIS) begin
      nxt_rdata = {31'h00000000, ris_ff};
    end else if (addr_i == `WDT_OFS_MIS) begin
      nxt_rdata = {31'h00000000, ris_ff && run_ff};
    end else if (addr_i == `WDT_OFS_LOCK) begin
      nxt_rdata = {31'h00000000, locked};
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      rdata_o <= rd_i ? nxt_rdata : 32'h00000000;
    end
  end
endmodule // wdt_top
`default_nettype wire

/* File: src/wdt_regs.vh */
// Behaviour
// - the timeout counter is a 32-bit down counter loaded from the load register.
// - once the lock is engaged, writes that would change the configuration have no effect.
// - the first timeout can raise an interrupt to the processor.
// - the first timeout is signalled when the enabled counter decrements to zero.
// - enabling the counter also enables the timeout interrupt.
// - after the first timeout the counter reloads from the load register and keeps counting.
// - a second zero while the interrupt is uncleared asserts reset if reset generation is on.
// - clearing the interrupt before the second timeout reloads the counter and resumes.
// - writing the load register while running loads the counter at once.
// - writing a load value of zero raises the timeout interrupt immediately.
// - software can read both raw and masked interrupt status.
// - a software enable decides whether a second timeout resets; locked while locked.
// - software can read whether the configuration is locked.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
`define WDT_ADDR_W      4
`define WDT_OFS_LOAD    4'h0
`define WDT_OFS_VALUE   4'h1
`define WDT_OFS_CTRL    4'h2
`define WDT_OFS_ICLR    4'h3
`define WDT_OFS_RIS     4'h4
`define WDT_OFS_MIS     4'h5
`define WDT_OFS_LOCK    4'h6
`define WDT_CTRL_INTEN  0
`define WDT_CTRL_RESEN  1
`define WDT_LOAD_RST    32'hffffffff
`define WDT_UNLOCK_KEY  32'h1acce551
`endif

/* File: src/wdt_lock.v */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_lock (
  input  wire        clock_i,
  input  wire        resetn_i,
  input  wire        ce_i,
  input  wire        wr_i,
  input  wire [31:0] wdata_i,
  output wire        locked_o
);
  reg locked_ff;
  // any value but the key engages; the key alone releases
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      locked_ff <= 1'b0;
    end else if (ce_i && wr_i) begin
      locked_ff <= (wdata_i != `WDT_UNLOCK_KEY);
    end
  end
  assign locked_o = locked_ff;
endmodule // wdt_lock
`default_nettype wire

/* File: sim/wdt_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"
module wdt_props (
  input wire logic                   clock_i, resetn_i, ce_i, wr_i, rd_i,
  input wire logic [`WDT_ADDR_W-1:0] addr_i,
  input wire logic [31:0]            wdata_i, rdata_o,
  input wire logic                   irq_o, sys_reset_o
);
  logic lk_ff, en_ff;
  wire  wr = ce_i && wr_i && !lk_ff;
  // shadows of lock and enable, so effects can be tied to their cause
  always_ff @(posedge clock_i or negedge resetn_i)
    if (!resetn_i) begin
      lk_ff <= 1'b0;
      en_ff <= 1'b0;
    end else if (ce_i && wr_i) begin
      if (addr_i == 4'h6) lk_ff <= wdata_i != `WDT_UNLOCK_KEY;
      if (wr && addr_i == 4'h2 && wdata_i[0]) en_ff <= 1'b1;
    end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  rd_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 0) else $error("stray data");
  val_rd_a: assert property (wr && addr_i == 0 ##1 ce_i && rd_i && addr_i == 1
    |=> rdata_o == $past(wdata_i, 2)) else $error("load not in count");
  lock_rd_a: assert property (ce_i && rd_i && addr_i == 6
    |=> rdata_o == {31'h0, $past(lk_ff)}) else $error("lock state wrong");
  mis_rd_a: assert property (ce_i && rd_i && addr_i == 5
    |=> rdata_o == {31'h0, $past(irq_o)}) else $error("masked status wrong");
  zero_irq_a: assert property (wr && addr_i == 0 && wdata_i == 0 && en_ff |=> irq_o)
    else $error("no irq on zero load");
  irq_off_a: assert property (!en_ff |-> !irq_o) else $error("irq while stopped");
  rst_hold_a: assert property (sys_reset_o |=> sys_reset_o) else $error("reset dropped");
  rst_cause_a: assert property ($rose(sys_reset_o) |-> $past(irq_o)) else $error("early reset");
  cover property (irq_o);
  cover property ($rose(sys_reset_o));
  cover property (lk_ff && wr_i);
endmodule // wdt_props
bind wdt_top wdt_props u_props (.clock_i, .resetn_i, .ce_i, .wr_i, .rd_i, .addr_i, .wdata_i,
  .rdata_o, .irq_o, .sys_reset_o);
`default_nettype wire

/* File: sim/test_two_stage_watchdog_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.vh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module test_two_stage_watchdog_timer;
  logic        clock_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, ce_i = 1;
  logic [3:0]  addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, ld;
  wire         irq_o, sys_reset_o;
  integer      fail_count = 0, n_compared = 0, seed = 82140, i;
  always #5 clock_i = ~clock_i;
  wdt_top uut (.clock_i, .resetn_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .irq_o, .sys_reset_o);
  task report_and_stop;
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task bus(input w, input r, input [3:0] a, input [31:0] d);
    wr_i <= w; rd_i <= r; addr_i <= a; wdata_i <= d;
    @(posedge clock_i);
  endtask
  task rd(input [3:0] a, input [31:0] e);
    bus(0, 1, a, 0);
    wr_i <= 0;
    rd_i <= 0;
    // data launched at the read edge is still standing at this one
    @(posedge clock_i);
    `CHK("rdata", e, rdata_o)
  endtask
  // bounded wait for irq (s=0) or system reset (s=1)
  task wt(input s);
    for (i = 0; i < 99 && (s ? sys_reset_o : irq_o) !== 1'b1; i++) bus(0, 0, 0, 0);
    `CHK("line", 1'b1, s ? sys_reset_o : irq_o)
    if (i == 99) report_and_stop;
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    resetn_i <= 1;
    rd(6, 0);
    rd(0, `WDT_LOAD_RST);
    ld = 8 + {$random(seed)} % 8;
    bus(1, 0, 0, ld);
    rd(1, ld);
    bus(1, 0, 2, 3);
    wt(0);
    rd(4, 1);
    rd(5, 1);
    wt(1);
    resetn_i <= 0;
    bus(0, 0, 0, 0);
    resetn_i <= 1;
    bus(1, 0, 6, 0);
    rd(6, 1);
    bus(1, 0, 0, 5);
    rd(1, `WDT_LOAD_RST);
    bus(1, 0, 6, `WDT_UNLOCK_KEY);
    rd(6, 0);
    bus(1, 0, 2, 1);
    bus(1, 0, 0, 0);
    rd(4, 1);
    // a clear while the enable is low must be lost
    ce_i <= 0;
    bus(1, 0, 3, 0);
    bus(0, 0, 0, 0);
    ce_i <= 1;
    rd(4, 1);
    bus(1, 0, 0, 20);
    bus(1, 0, 3, 0);
    rd(4, 0);
    wt(0);
    repeat (30) bus(0, 0, 0, 0);
    `CHK("reset", 1'b0, sys_reset_o)
    report_and_stop;
  end
endmodule // test_two_stage_watchdog_timer
`default_nettype wire
